// *** rtl/ucq_decoder.sv ***
/*
 Command decoder: takes OUT packets (address byte then data bytes,
 most significant first), applies configuration and answers queries
 on the IN byte stream. Holds the 16k user memory itself and reads
 the factory memory through a port with one cycle of read latency.
 Assumes cmd_last marks the final byte of each packet.
*/
module ucq_decoder (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_last,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [7:0] rsp_data,
    output logic rsp_last,
    output logic [13:0] fac_addr,
    input wire logic [7:0] fac_rdata,
    input wire logic [7:0] pll_lock,
    input wire logic ref_clk_detect,
    input wire logic high_band_path,
    input wire logic standby,
    input wire logic [13:0] temp_code,
    output logic fast_tune,
    output logic [1:0] step_select,
    output logic second_filter_path,
    output logic tone_enable,
    output logic ref_lock_attempt,
    output logic ref_out_enable,
    output logic ref_out_100m,
    output logic [15:0] ref_dac_word,
    output logic ref_dac_load,
    output logic spectrum_invert,
    output logic [3:0] phase_tenths,
    output logic [9:0] phase_units
);
    typedef enum logic [2:0] {
        ST_BOOT_WAIT, ST_BOOT_TAKE, ST_IDLE, ST_WAIT, ST_TAKE, ST_SEND
    } ucq_state_t;

    ucq_state_t state_q;
    logic [7:0] op_q;
    logic [2:0] nbytes_q;
    logic [23:0] arg_q;
    logic exec_q, enough_q;
    logic [7:0] ref_beh_q;
    logic fast_q, filt_q, tone_q, inv_q, attempt_q, load_q, boot_idx_q;
    logic [1:0] step_q;
    logic [15:0] dac_q, phase_q, word_q;
    logic [13:0] rd_addr_q;
    logic user_src_q, bulk_q, half_q;
    logic [5:0] cnt_q;
    logic [7:0] rsp_q, user_rd_q;
    logic [ucq_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, stab_q;
    logic [7:0] user_mem [ucq_pkg::MEM_DEPTH];

    // ==========================================================
    // Decode
    logic cmd_take, rsp_take, first_byte, shift_en, enough;
    logic [2:0] need;
    logic [7:0] mem_byte;
    logic [15:0] status_word;
    logic is_user_wr, is_user_src;

    assign cmd_ready = (state_q == ST_IDLE) && !exec_q;
    assign cmd_take = cmd_valid && cmd_ready;
    assign first_byte = (nbytes_q == 3'h0);
    assign rsp_valid = (state_q == ST_SEND);
    assign rsp_take = rsp_valid && rsp_ready;
    assign rsp_data = rsp_q;
    assign rsp_last = bulk_q ? (cnt_q == ucq_pkg::BLOCK_LAST) : half_q;
    assign fac_addr = rd_addr_q;
    assign mem_byte = user_src_q ? user_rd_q : fac_rdata;
    assign need = (op_q == ucq_pkg::OP_USER_BYTE_WRITE) ? 3'h3 :
                  (op_q == ucq_pkg::OP_REF_TUNING || op_q == ucq_pkg::OP_PHASE_OFFSET ||
                   op_q == ucq_pkg::OP_FAC_BYTE_QUERY || op_q == ucq_pkg::OP_USER_BYTE_QUERY ||
                   op_q == ucq_pkg::OP_FAC_BLOCK_QUERY ||
                   op_q == ucq_pkg::OP_USER_BLOCK_QUERY) ? 3'h2 : 3'h1;
    // Extra data bytes beyond what a command needs are dropped
    assign shift_en = cmd_take && !first_byte && (nbytes_q <= need);
    // Judged on the last byte, since the byte count clears as that byte is taken
    assign enough = enough_q;
    assign is_user_src = (op_q == ucq_pkg::OP_USER_BYTE_QUERY) || (op_q == ucq_pkg::OP_USER_BLOCK_QUERY);
    assign is_user_wr = exec_q && enough && (op_q == ucq_pkg::OP_USER_BYTE_WRITE);
    // Bit 1 of the status word is reserved and reads zero
    assign status_word = {stab_q[7:0], stab_q[8], ref_out_enable, ref_beh_q[ucq_pkg::LOCK_EN_BIT],
                          filt_q, stab_q[9], stab_q[10], 1'b0, tone_q};

    assign fast_tune = fast_q;
    assign step_select = step_q;
    assign second_filter_path = filt_q;
    assign tone_enable = tone_q;
    assign ref_lock_attempt = attempt_q;
    assign ref_out_enable = ref_beh_q[ucq_pkg::REF_OUT_BIT];
    assign ref_out_100m = ref_beh_q[ucq_pkg::REF_OUT_BIT] & ref_beh_q[ucq_pkg::REF_100M_BIT];
    assign ref_dac_word = dac_q;
    assign ref_dac_load = load_q;
    assign spectrum_invert = inv_q;
    assign phase_tenths = phase_q[3:0];
    assign phase_units = phase_q[13:4];

    // ==========================================================
    // Status input synchroniser
    logic [ucq_pkg::SYNC_W-1:0] sync_in;
    assign sync_in = {standby, high_band_path, ref_clk_detect, pll_lock};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            stab_q <= '0;
        end else begin
            s1_q <= sync_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < ucq_pkg::SYNC_W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    stab_q[i] <= s3_q[i];
                end
            end
        end
    end

    // Lock is only attempted with a reference actually present
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            attempt_q <= 1'b0;
        end else begin
            attempt_q <= ref_beh_q[ucq_pkg::LOCK_EN_BIT] & stab_q[8];
        end
    end

    // ==========================================================
    // User memory, no reset; addresses wrap at 14 bits
    always_ff @(posedge mclk) begin
        if (is_user_wr) begin
            user_mem[arg_q[21:8]] <= arg_q[7:0];
        end
        user_rd_q <= user_mem[rd_addr_q];
    end

    // ==========================================================
    // Packet reception
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            op_q <= 8'h00;
            nbytes_q <= 3'h0;
            arg_q <= 24'h000000;
            exec_q <= 1'b0;
            enough_q <= 1'b0;
        end else begin
            exec_q <= cmd_take && cmd_last;
            if (cmd_take && first_byte) begin
                op_q <= cmd_data;
            end
            if (shift_en) begin
                arg_q <= {arg_q[15:0], cmd_data};
            end
            if (cmd_take && cmd_last) begin
                nbytes_q <= 3'h0;
                // Bytes taken before the last one equal the data bytes of the packet
                enough_q <= (nbytes_q >= need);
            end else if (cmd_take && nbytes_q != 3'h7) begin
                nbytes_q <= nbytes_q + 3'h1;
            end
        end
    end

    // ==========================================================
    // Configuration settings; only documented bits are kept
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fast_q <= 1'b0;
            step_q <= ucq_pkg::STEP_1MHZ;
            filt_q <= 1'b0;
            tone_q <= 1'b0;
            ref_beh_q <= ucq_pkg::REF_BEHAVIOUR_RST;
            inv_q <= 1'b0;
            phase_q <= 16'h0000;
        end else if (exec_q && enough) begin
            case (op_q)
                ucq_pkg::OP_TUNING_MODE: begin
                    fast_q <= arg_q[ucq_pkg::FAST_TUNE_BIT];
                    // Code 3 has no meaning and leaves the step alone
                    if (arg_q[1:0] != 2'h3) begin
                        step_q <= arg_q[1:0];
                    end
                end
                ucq_pkg::OP_FILTER_PATH: filt_q <= arg_q[ucq_pkg::ENABLE_BIT];
                ucq_pkg::OP_TONE_ENABLE: tone_q <= arg_q[ucq_pkg::ENABLE_BIT];
                ucq_pkg::OP_REF_BEHAVIOUR: ref_beh_q <= {5'h00, arg_q[2:0]};
                ucq_pkg::OP_SPEC_INVERT: inv_q <= arg_q[ucq_pkg::ENABLE_BIT];
                ucq_pkg::OP_PHASE_OFFSET: phase_q <= {2'h0, arg_q[13:0]};
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Boot load, memory fetch and response sequencing
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_BOOT_WAIT;
            rd_addr_q <= ucq_pkg::CAL_DAC_ADDR;
            user_src_q <= 1'b0;
            boot_idx_q <= 1'b0;
            dac_q <= 16'h0000;
            load_q <= 1'b0;
            bulk_q <= 1'b0;
            half_q <= 1'b0;
            cnt_q <= 6'h00;
            word_q <= 16'h0000;
            rsp_q <= 8'h00;
        end else begin
            load_q <= 1'b0;
            case (state_q)
                ST_BOOT_WAIT: state_q <= ST_BOOT_TAKE;
                ST_BOOT_TAKE: begin
                    // Tuning word sits low byte first in factory memory
                    // Low byte is parked so the converter never sees half a word
                    if (boot_idx_q) begin
                        dac_q <= {fac_rdata, word_q[7:0]};
                        load_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        word_q[7:0] <= fac_rdata;
                        boot_idx_q <= 1'b1;
                        rd_addr_q <= rd_addr_q + 14'h0001;
                        state_q <= ST_BOOT_WAIT;
                    end
                end
                ST_IDLE: begin
                    if (exec_q && enough) begin
                        bulk_q <= 1'b0;
                        half_q <= 1'b0;
                        cnt_q <= 6'h00;
                        rd_addr_q <= arg_q[13:0];
                        user_src_q <= is_user_src;
                        case (op_q)
                            ucq_pkg::OP_REF_TUNING: begin
                                dac_q <= arg_q[15:0];
                                load_q <= 1'b1;
                            end
                            ucq_pkg::OP_STATUS_QUERY: begin
                                word_q <= status_word;
                                rsp_q <= status_word[15:8];
                                state_q <= ST_SEND;
                            end
                            ucq_pkg::OP_TEMP_QUERY: begin
                                word_q <= {2'h0, temp_code};
                                rsp_q <= {2'h0, temp_code[13:8]};
                                state_q <= ST_SEND;
                            end
                            ucq_pkg::OP_FAC_BYTE_QUERY, ucq_pkg::OP_USER_BYTE_QUERY: begin
                                state_q <= ST_WAIT;
                            end
                            ucq_pkg::OP_FAC_BLOCK_QUERY, ucq_pkg::OP_USER_BLOCK_QUERY: begin
                                bulk_q <= 1'b1;
                                state_q <= ST_WAIT;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_WAIT: state_q <= ST_TAKE;
                ST_TAKE: begin
                    if (bulk_q) begin
                        rsp_q <= mem_byte;
                    end else begin
                        // Leading byte carries nothing for a single byte read
                        word_q <= {8'h00, mem_byte};
                        rsp_q <= 8'h00;
                    end
                    state_q <= ST_SEND;
                end
                ST_SEND: begin
                    if (rsp_take) begin
                        if (bulk_q) begin
                            if (cnt_q == ucq_pkg::BLOCK_LAST) begin
                                state_q <= ST_IDLE;
                            end else begin
                                cnt_q <= cnt_q + 6'h01;
                                rd_addr_q <= rd_addr_q + 14'h0001;
                                state_q <= ST_WAIT;
                            end
                        end else if (half_q) begin
                            state_q <= ST_IDLE;
                        end else begin
                            half_q <= 1'b1;
                            rsp_q <= word_q[7:0];
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// *** include/ucq_pkg.sv ***
/*
 Constants for the USB configuration and query command decoder:
 command addresses, field positions and sizes, reset values.
 Assumes the USB core hands over each OUT packet as a byte stream.
*/
package ucq_pkg;
    // ==========================================================
    // Command addresses
    localparam logic [7:0] OP_TUNING_MODE = 8'h13;
    localparam logic [7:0] OP_FILTER_PATH = 8'h15;
    localparam logic [7:0] OP_REF_BEHAVIOUR = 8'h16;
    localparam logic [7:0] OP_REF_TUNING = 8'h17;
    localparam logic [7:0] OP_STATUS_QUERY = 8'h18;
    localparam logic [7:0] OP_TEMP_QUERY = 8'h19;
    localparam logic [7:0] OP_TONE_ENABLE = 8'h1b;
    localparam logic [7:0] OP_SPEC_INVERT = 8'h1d;
    localparam logic [7:0] OP_FAC_BYTE_QUERY = 8'h20;
    localparam logic [7:0] OP_USER_BYTE_QUERY = 8'h22;
    localparam logic [7:0] OP_USER_BYTE_WRITE = 8'h23;
    localparam logic [7:0] OP_FAC_BLOCK_QUERY = 8'h24;
    localparam logic [7:0] OP_USER_BLOCK_QUERY = 8'h25;
    localparam logic [7:0] OP_PHASE_OFFSET = 8'h32;
    // ==========================================================
    // Field positions and sizes
    localparam int FAST_TUNE_BIT = 3;
    localparam int LOCK_EN_BIT = 0;
    localparam int REF_OUT_BIT = 1;
    localparam int REF_100M_BIT = 2;
    localparam int ENABLE_BIT = 0;
    localparam int MEM_AW = 14;
    localparam int MEM_DEPTH = 16384;
    localparam logic [5:0] BLOCK_LAST = 6'h3f;
    localparam logic [1:0] STEP_1MHZ = 2'h0;
    localparam logic [1:0] STEP_25KHZ = 2'h1;
    localparam logic [1:0] STEP_1HZ = 2'h2;
    localparam logic [7:0] REF_BEHAVIOUR_RST = 8'h00;
    // Factory memory location of the reference tuning word, LSB first
    localparam logic [13:0] CAL_DAC_ADDR = 14'h0060;
    // Sync vector: [7:0] PLL locks (status 15:8), [8] ref detect,
    // [9] high band path, [10] standby
    localparam int SYNC_W = 11;
endpackage

// *** verification/ucq_fac_model.sv ***
/*
 Factory memory model for the decoder's read port.
 Assumes the decoder expects data one clock edge after the address.
*/
module ucq_fac_model (
    input wire logic mclk,
    input wire logic [13:0] fac_addr,
    output logic [7:0] fac_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Registered read
    // Content mixes both address bytes so a lost upper bit shows up
    always_ff @(posedge mclk) begin
        fac_rdata <= fac_addr[7:0] + {2'h0, fac_addr[13:8]};
    end
endmodule

// *** verification/ucq_decoder_asserts.sv ***
/*
 Port checker for the command decoder.
 Assumes one clock domain and the hand-over timing of the decoder.
*/
module ucq_decoder_asserts (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last,
    input wire logic ref_clk_detect,
    input wire logic fast_tune,
    input wire logic second_filter_path,
    input wire logic tone_enable,
    input wire logic spectrum_invert,
    input wire logic ref_lock_attempt,
    input wire logic ref_out_enable,
    input wire logic ref_out_100m,
    input wire logic [15:0] ref_dac_word,
    input wire logic ref_dac_load
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Properties
    property p_ref_100m; ref_out_100m |-> ref_out_enable; endproperty
    a_ref_100m: assert property (p_ref_100m) else $error("fast export without output enable");
    property p_lock_quiet; !ref_clk_detect [*5] |=> !ref_lock_attempt; endproperty
    a_lock_quiet: assert property (p_lock_quiet) else $error("lock attempt without reference");
    property p_cfg_reset;
        $rose(rst_n) |-> !fast_tune && !tone_enable && !ref_out_enable && !ref_lock_attempt;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("setting not cleared by reset");
    property p_boot_load; $rose(rst_n) |-> ##[1:12] ref_dac_load; endproperty
    a_boot_load: assert property (p_boot_load) else $error("no tuning word load after reset");
    property p_dac_change; $changed(ref_dac_word) |-> ref_dac_load; endproperty
    a_dac_change: assert property (p_dac_change) else $error("tuning word changed silently");
    property p_dac_pulse; ref_dac_load |=> !ref_dac_load; endproperty
    a_dac_pulse: assert property (p_dac_pulse) else $error("load pulse too long");
    property p_rsp_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last);
    endproperty
    a_rsp_hold: assert property (p_rsp_hold) else $error("response byte dropped");
    property p_rsp_excl; rsp_valid |-> !cmd_ready; endproperty
    a_rsp_excl: assert property (p_rsp_excl) else $error("command taken during response");
    property p_cfg_exec;
        $changed({fast_tune, second_filter_path, tone_enable, spectrum_invert}) |-> !$past(cmd_ready);
    endproperty
    a_cfg_exec: assert property (p_cfg_exec) else $error("setting changed outside command");
endmodule

bind ucq_decoder ucq_decoder_asserts u_chk (.mclk, .rst_n, .cmd_ready, .rsp_valid, .rsp_ready, .rsp_data,
    .rsp_last, .ref_clk_detect, .fast_tune, .second_filter_path, .tone_enable, .spectrum_invert,
    .ref_lock_attempt, .ref_out_enable, .ref_out_100m, .ref_dac_word, .ref_dac_load);

// *** verification/test_usb_config_query_command_decoder.sv ***
/*
 Self-checking bench for the command decoder.
 Assumes the factory memory model and the bound port checker.
*/
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_usb_config_query_command_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] op; int n; logic [23:0] d; logic [37:0] e;} ucq_row_t;
    logic mclk, rst_n, cmd_valid, cmd_ready, cmd_last, rsp_valid, rsp_ready, rsp_last;
    logic ref_clk_detect, high_band_path, standby, fast_tune, second_filter_path, tone_enable;
    logic ref_lock_attempt, ref_out_enable, ref_out_100m, ref_dac_load, spectrum_invert, l;
    logic [7:0] cmd_data, rsp_data, fac_rdata, pll_lock, b;
    logic [13:0] fac_addr, temp_code, a;
    logic [1:0] step_select;
    logic [15:0] ref_dac_word;
    logic [3:0] phase_tenths;
    logic [9:0] phase_units;
    logic [37:0] cfg;
    ucq_row_t rows[16];
    int err_total = 0;
    int n_tests = 0;
    assign cfg = {fast_tune, step_select, second_filter_path, tone_enable, ref_out_enable, ref_out_100m,
        spectrum_invert, phase_tenths, phase_units, ref_dac_word};
    ucq_decoder dut (.mclk, .rst_n, .cmd_valid, .cmd_ready, .cmd_data, .cmd_last, .rsp_valid, .rsp_ready,
        .rsp_data, .rsp_last, .fac_addr, .fac_rdata, .pll_lock, .ref_clk_detect, .high_band_path, .standby,
        .temp_code, .fast_tune, .step_select, .second_filter_path, .tone_enable, .ref_lock_attempt,
        .ref_out_enable, .ref_out_100m, .ref_dac_word, .ref_dac_load, .spectrum_invert, .phase_tenths,
        .phase_units);
    ucq_fac_model u_fac (.mclk, .fac_addr, .fac_rdata);
    initial begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    // ==========================================================
    // Helpers
    function automatic logic [37:0] e(logic [7:0] f, logic [13:0] ph, logic [15:0] dac);
        return {f, ph[3:0], ph[13:4], dac};
    endfunction
    task automatic final_report;
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic put(logic [7:0] v, logic last);
        int i;
        cmd_valid = 1;
        cmd_data = v;
        cmd_last = last;
        for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge mclk);
        if (cmd_ready !== 1'b1) begin
            err_total++;
            final_report();
        end
        @(negedge mclk);
    endtask
    // Data bytes go most significant first; the bus shows junk once released
    task automatic send(logic [7:0] op, int n, logic [23:0] d);
        put(op, n == 0);
        for (int k = n - 1; k >= 0; k--) put(d[8*k +: 8], k == 0);
        cmd_valid = 0;
        cmd_data = ~cmd_data;
        cmd_last = 0;
        // An edge passes so a following send never drives cmd_valid twice at once
        @(negedge mclk);
    endtask
    // Waits one edge before looking, so only a byte already offered on entry is stalled and holds
    task automatic get;
        int i;
        i = 0;
        do begin
            @(negedge mclk);
            i++;
        end while (rsp_valid !== 1'b1 && i < 50);
        if (rsp_valid !== 1'b1) begin
            err_total++;
            final_report();
        end
        b = rsp_data;
        l = rsp_last;
        rsp_ready = 1;
        @(negedge mclk);
        rsp_ready = 0;
    endtask
    task automatic query(logic [7:0] op, int n, logic [23:0] d, logic [15:0] x);
        send(op, n, d);
        get();
        `CHK({b, l}, {x[15:8], 1'b0})
        get();
        `CHK({b, l}, {x[7:0], 1'b1})
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        rst_n = 0; cmd_valid = 0; cmd_data = 8'h00; cmd_last = 0; rsp_ready = 0; pll_lock = 8'h5a;
        ref_clk_detect = 0; high_band_path = 1; standby = 0; temp_code = 14'h2abc;
        rows = '{'{8'h13, 1, 24'h06, e(8'h40, 14'h0, 16'h6160)}, '{8'h13, 1, 24'h09, e(8'ha0, 14'h0, 16'h6160)},
            '{8'h13, 1, 24'hf0, e(8'h00, 14'h0, 16'h6160)}, '{8'h13, 1, 24'h0b, e(8'h80, 14'h0, 16'h6160)},
            '{8'h15, 1, 24'hfe, e(8'h80, 14'h0, 16'h6160)}, '{8'h15, 1, 24'h01, e(8'h90, 14'h0, 16'h6160)},
            '{8'h1b, 1, 24'h01, e(8'h98, 14'h0, 16'h6160)}, '{8'h16, 1, 24'h06, e(8'h9e, 14'h0, 16'h6160)},
            '{8'h16, 1, 24'h02, e(8'h9c, 14'h0, 16'h6160)}, '{8'h16, 1, 24'h04, e(8'h98, 14'h0, 16'h6160)},
            '{8'h1d, 1, 24'h01, e(8'h99, 14'h0, 16'h6160)}, '{8'h17, 2, 24'hbeef, e(8'h99, 14'h0, 16'hbeef)},
            '{8'h32, 2, 24'he10c, e(8'h99, 14'h210c, 16'hbeef)}, '{8'h40, 1, 24'hff, e(8'h99, 14'h210c, 16'hbeef)},
            '{8'h17, 1, 24'h12, e(8'h99, 14'h210c, 16'hbeef)}, '{8'h1b, 1, 24'hfe, e(8'h91, 14'h210c, 16'hbeef)}};
        repeat (8) @(negedge mclk);
        rst_n = 1;
        repeat (12) @(negedge mclk);
        `CHK(cfg, e(8'h00, 14'h0, 16'h6160))
        foreach (rows[r]) begin
            send(rows[r].op, rows[r].n, rows[r].d);
            repeat (2) @(negedge mclk);
            `CHK(cfg, rows[r].e)
        end
        send(8'h16, 1, 24'h03);
        repeat (10) @(negedge mclk);
        `CHK(ref_lock_attempt, 1'b0)
        ref_clk_detect = 1;
        repeat (8) @(negedge mclk);
        `CHK(ref_lock_attempt, 1'b1)
        query(8'h18, 1, 24'h00, 16'h5af8);
        query(8'h19, 1, 24'h00, 16'h2abc);
        send(8'h23, 3, 24'h3fff7b);
        repeat (5) @(negedge mclk); // Host pause between memory writes
        send(8'h23, 3, 24'h4000c3);
        query(8'h22, 2, 24'h4000, 16'h00c3);
        query(8'h22, 2, 24'h3fff, 16'h007b);
        query(8'h20, 2, 24'h4061, 16'h0061);
        send(8'h24, 2, 24'h3fe0);
        for (int k = 0; k < 64; k++) begin
            a = 14'h3fe0 + 14'(k);
            get();
            `CHK({b, l}, {a[7:0] + {2'h0, a[13:8]}, k == 63})
        end
        rst_n = 0;
        repeat (2) @(negedge mclk);
        rst_n = 1;
        repeat (12) @(negedge mclk);
        `CHK({cfg, ref_lock_attempt}, {e(8'h00, 14'h0, 16'h6160), 1'b0})
        final_report();
    end
endmodule
